// ---- dv/tape_ctrl_model.sv ----
module tape_ctrl_model (
	input  wire logic mclk,
	input  wire logic rst_b,
	input  wire logic want_write,
	input  wire logic tape_end_flag,
	input  wire logic write_permit,
	output logic      unit_select,
	output logic      if_go,
	output logic      if_set_write,
	output logic      data_ok
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] eot_cnt_r;
	// slow reaction, so the unit is seen to keep writing by itself
	always_ff @(posedge mclk) begin
		if (!rst_b || !tape_end_flag) begin
			eot_cnt_r <= 4'h0;
		end else if (eot_cnt_r != 4'h8) begin
			eot_cnt_r <= eot_cnt_r + 4'h1;
		end
	end
	// host wish turned into select and write run
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			{unit_select, if_go, if_set_write, data_ok} <= 4'h0;
		end else begin
			unit_select <= want_write;
			if_go <= want_write && eot_cnt_r != 4'h8;
			if_set_write <= want_write && eot_cnt_r != 4'h8;
			data_ok <= want_write && write_permit;
		end
	end
endmodule : tape_ctrl_model

// ---- dv/tape_seq_props.sv ----
module tape_seq_props #(
	parameter int unsigned PWROFF_STEP_CYC = 2
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic unit_select,
	input wire logic sns_write_ring,
	input wire logic sns_broken,
	input wire logic run_normal_line,
	input wire logic run_fast_line,
	input wire logic reverse_dir_line,
	input wire logic tape_broken,
	input wire logic unload,
	input wire logic main_power_relay,
	input wire logic vacuum_on,
	input wire logic sensor_disable,
	input wire logic servo_disable,
	input wire logic write_permit,
	input wire logic write_drivers_on,
	input wire logic lamp_write,
	input wire logic selected_and_online,
	input wire logic read_select
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// capstan quiet and servos off
	sequence s_halt;
		servo_disable && !run_normal_line && !run_fast_line && !reverse_dir_line;
	endsequence
	sequence s_safe_off;
		servo_disable && sensor_disable && !vacuum_on;
	endsequence
	property p_one_motion;
		$onehot0({run_normal_line, run_fast_line, reverse_dir_line});
	endproperty
	property p_halt;
		$rose(tape_broken) |-> ##[0:2] s_halt;
	endproperty
	property p_drivers;
		$rose(write_permit) |-> ##[0:1] (write_drivers_on && lamp_write);
	endproperty
	property p_no_read;
		write_permit [*2] |-> !read_select;
	endproperty
	property p_sel;
		!unit_select [*3] |-> !selected_and_online;
	endproperty
	property p_ring;
		!sns_write_ring [*4] |-> !write_permit;
	endproperty
	// relay drops last; sensor disable seen a step before, vacuum off one cycle before that
	property p_power_seq;
		$fell(main_power_relay) |-> s_safe_off and
			($past(sensor_disable, PWROFF_STEP_CYC) && !$past(vacuum_on, PWROFF_STEP_CYC + 1));
	endproperty
	property p_unload_pwr;
		unload |-> main_power_relay;
	endproperty
	property p_unload_end;
		$fell(unload) |-> $past(sns_broken, 2) || $past(sns_broken, 3);
	endproperty
	a_one_motion: assert property (p_one_motion) else $error("motion overlap");
	a_halt: assert property (p_halt) else $error("no halt on break");
	a_drivers: assert property (p_drivers) else $error("heads off");
	a_no_read: assert property (p_no_read) else $error("read with write");
	a_sel: assert property (p_sel) else $error("selected w/o select");
	a_ring: assert property (p_ring) else $error("write w/o ring");
	a_power_seq: assert property (p_power_seq) else $error("off order");
	a_unload_pwr: assert property (p_unload_pwr) else $error("power in unload");
	a_unload_end: assert property (p_unload_end) else $error("unload end");
endmodule : tape_seq_props

bind tape_transport_sequence_interlock tape_seq_props #(.PWROFF_STEP_CYC(PWROFF_STEP_CYC))
	u_tape_seq_props (.mclk, .rst_b, .unit_select, .sns_write_ring, .sns_broken,
	.run_normal_line, .run_fast_line, .reverse_dir_line, .tape_broken, .unload,
	.main_power_relay, .vacuum_on, .sensor_disable, .servo_disable, .write_permit,
	.write_drivers_on, .lamp_write, .selected_and_online, .read_select);

// ---- dv/test_tape_transport_sequence_interlock.sv ----
module test_tape_transport_sequence_interlock;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LT = 50;
	localparam int PW = 0, LD = 1, OL = 2, RW = 3, TS = 4, TM = 5;
	localparam int TR = 6, TF = 7, TFA = 8, TC = 9, TW = 10;
	logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [10:0] pb;
	logic pb_power, pb_load, pb_online, pb_rewind, tp_stop, tp_mode, tp_rev, tp_fwd, tp_fast;
	logic tp_cycle, if_go, if_set_write, unit_select, want_write, data_ok;
	logic if_reverse, if_fast, if_rewind, if_offline, tp_write_test, skew_excess;
	logic sns_write_ring, sns_load_point, sns_end_of_tape, sns_broken, vacuum_ok;
	logic tape_end_flag, at_load_point, file_protect, online, rewinding;
	logic run_normal_line, run_fast_line, reverse_dir_line, tape_broken, unload;
	logic main_power_relay, reel_motor_relay, vacuum_on, sensor_disable, servo_disable;
	logic write_permit, write_drivers_on, selected_and_online, write_amp_enable, read_select;
	logic read_amp_enable, test_active, write_test_on, lamp_write, lamp_read, lamp_load;
	logic lamp_skew, lamp_high_dens, lamp_eot, lamp_load_point;
	logic [8:0] test_pattern;
	int n_fail = 0, total_checks = 0, cyc = 0, k;
	assign {tp_write_test, tp_cycle, tp_fast, tp_fwd, tp_rev, tp_mode, tp_stop} = pb[10:4];
	assign {pb_rewind, pb_online, pb_load, pb_power} = pb[3:0];
	tape_transport_sequence_interlock #(.LOAD_TIMEOUT_CYC(LT), .PWROFF_STEP_CYC(2))
		u_tape_transport_sequence_interlock (.*);
	tape_ctrl_model u_tape_ctrl_model (.*);
	initial begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end
	// hang guard, far above the whole sequence
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			conclude();
		end
	end
	task conclude();
		if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : conclude
	task cy(int n);
		repeat (n) @(posedge mclk);
	endtask : cy
	task chk(logic [31:0] a, logic [31:0] e);
		total_checks++;
		if (a !== e) begin
			n_fail++;
			$display("ERROR t=%0t got %h exp %h", $time, a, e);
		end
	endtask : chk
	task automatic wt(ref logic s, input logic v);
		for (int i = 0; i < 200 && s !== v; i++) cy(1);
	endtask : wt
	// buttons act on the press edge, so hold two cycles then settle
	task press(int i);
		pb[i] <= 1'b1;
		cy(2);
		pb[i] <= 1'b0;
		cy(4);
	endtask : press
	task apb(bit w, logic [7:0] a, logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		cy(1);
		penable <= 1'b1;
		do cy(1); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		cy(1);
	endtask : apb
	task t_regs();
		apb(0, 8'h00, 32'h0);
		chk(rd, 32'h0);
		apb(0, 8'h04, 32'h0);
		chk(rd, 32'h0100_0000);
		apb(1, 8'h04, 32'h3);
		apb(1, 8'h00, 32'h1);
		apb(0, 8'h04, 32'h0);
		chk(rd, 32'h3);
		apb(0, 8'h00, 32'h0);
		chk(rd, 32'h1);
		apb(0, 8'h0C, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(0, 8'h08, 32'h0);
		chk(rd[2:0], 3'h0);
	endtask : t_regs
	task t_load();
		press(PW);
		vacuum_ok <= 1'b1;
		press(LD);
		wt(run_normal_line, 1);
		chk(run_normal_line & reel_motor_relay & lamp_load, 1);
		sns_load_point <= 1'b1;
		cy(5);
		chk(run_normal_line, 0);
		chk(read_select, 1);
		chk(at_load_point, 0);
	endtask : t_load
	task t_write();
		sns_write_ring <= 1'b1;
		want_write <= 1'b1;
		cy(8);
		chk(write_permit, 0);
		press(OL);
		wt(write_permit, 1);
		chk(write_permit, 1);
		chk(write_drivers_on & lamp_write, 1);
		chk(read_select, 0);
		chk(selected_and_online & write_amp_enable, 1);
		chk({at_load_point, file_protect, online, rewinding}, 4'hA);
		sns_load_point <= 1'b0;
		sns_end_of_tape <= 1'b1;
		wt(tape_end_flag, 1);
		chk({tape_end_flag, write_permit}, 2'h3);
		chk(data_ok, 1);
		wt(write_permit, 0);
		// model output lags write permit by one edge
		cy(1);
		chk(data_ok, 0);
		if_offline <= 1'b1;
		cy(3);
		chk(online, 0);
		if_offline <= 1'b0;
		want_write <= 1'b0;
		sns_end_of_tape <= 1'b0;
		cy(4);
	endtask : t_write
	task t_unload();
		press(OL);
		press(RW);
		chk(reverse_dir_line, 0);
		press(OL);
		press(RW);
		chk(reverse_dir_line, 1);
		sns_load_point <= 1'b1;
		wt(reverse_dir_line, 0);
		press(RW);
		chk(unload, 1);
		press(PW);
		chk(unload & main_power_relay, 1);
		sns_broken <= 1'b1;
		wt(unload, 0);
		chk(unload, 0);
		sns_broken <= 1'b0;
		sns_load_point <= 1'b0;
	endtask : t_unload
	task t_timeout();
		press(LD);
		wt(run_normal_line, 1);
		for (k = 0; k < 200 && reverse_dir_line !== 1'b1; k++) cy(1);
		chk(k > LT - 12 && k < LT + 8, 1);
		chk(reverse_dir_line, 1);
		sns_load_point <= 1'b1;
		wt(reverse_dir_line, 0);
		chk(run_normal_line | run_fast_line, 0);
	endtask : t_timeout
	task t_test();
		press(TM);
		chk(test_active, 0);
		press(TS);
		press(TM);
		chk(test_active, 1);
		chk({read_amp_enable, lamp_read}, 2'h3);
		press(TF);
		chk({run_normal_line, run_fast_line, reverse_dir_line}, 3'h4);
		press(TFA);
		chk({run_normal_line, run_fast_line, reverse_dir_line}, 3'h2);
		press(TR);
		chk({run_normal_line, run_fast_line, reverse_dir_line}, 3'h1);
		skew_excess <= 1'b1;
		press(TC);
		wt(run_normal_line, 1);
		wt(reverse_dir_line, 1);
		chk(reverse_dir_line, 1);
		wt(run_normal_line, 1);
		chk(run_normal_line & lamp_skew, 1);
		press(TS);
		chk(run_normal_line | reverse_dir_line, 0);
		skew_excess <= 1'b0;
		press(TW);
		chk(test_pattern, 9'h1FF);
		chk({write_test_on, write_permit, write_amp_enable}, 3'h7);
		chk({lamp_high_dens, lamp_eot, lamp_load_point}, 3'h5);
	endtask : t_test
	task t_fault_off();
		vacuum_ok <= 1'b0;
		wt(tape_broken, 1);
		chk(tape_broken & servo_disable, 1);
		vacuum_ok <= 1'b1;
		press(PW);
		wt(main_power_relay, 0);
		chk({main_power_relay, vacuum_on, sensor_disable, servo_disable}, 4'h3);
	endtask : t_fault_off
	// every input set at time zero, reset held ten cycles
	initial begin
		{psel, penable, pwrite, paddr, pwdata, pb, want_write} = '0;
		{if_reverse, if_fast, if_rewind, if_offline, skew_excess} = '0;
		{sns_write_ring, sns_load_point, sns_end_of_tape, sns_broken, vacuum_ok} = '0;
		rst_b = 1'b0;
		cy(10);
		rst_b <= 1'b1;
		cy(1);
		t_regs();
		t_load();
		t_write();
		t_unload();
		t_timeout();
		t_test();
		t_fault_off();
		conclude();
	end
endmodule : test_tape_transport_sequence_interlock

// ---- rtl/tape_seq_defines.svh ----
`ifndef TAPE_SEQ_DEFINES_SVH
`define TAPE_SEQ_DEFINES_SVH
// Overview of operation
// - interface commands become transport commands only while all interlocks hold
// - with interlocks met, at most one of run normal, run fast, reverse is driven
// - file protect, load point and end of tape inputs are conditioned, gated, shared
// - broken tape or vacuum loss stops reels, flags broken, disables all servos
// - rewind button action depends on tape being before or at load point
// - after tension, run forward normal until load point, then stop
// - no load point within six seconds of load press starts a search rewind
// - end of tape never aborts a write; it is reported to the interface
// - unload needs offline and load point; rewind press then sets unload
// - unload ends when the broken tape signal goes true
// - power button is ignored throughout unload
// - power off steps: vacuum off, sensor disable, servo disable, power removed
// - select plus online opens the interface gates for commands and status
// - write permit needs write request, loaded, write ring, forward normal motion
// - write permit drives write and erase heads and write lamp
// - selected online is online and select; with write permit enables amplifiers
// - read is selected when loaded, not rewinding and no write permit
// - test panel works only offline after test stop then test mode presses
// - test mode writes timed all ones pattern and drives test lamps
// - cycle test alternates forward and reverse until stopped
// - local rewind button is disabled while online

`define CLK_FREQ_HZ       100000000
`define LOAD_TIMEOUT_MS   6000
`define LOAD_TIMEOUT_CYC  (`LOAD_TIMEOUT_MS * (`CLK_FREQ_HZ / 1000))
`define PWROFF_STEP_US    10
`define PWROFF_STEP_CYC   (`PWROFF_STEP_US * (`CLK_FREQ_HZ / 1000000))

`define REG_CTRL          8'h00
`define REG_CYCLE         8'h04
`define REG_STATUS        8'h08
`define CTRL_HIGH_DENS    0
`define CTRL_RST          1'h0
`define CYCLE_RST         32'h0100_0000
`define TEST_PATTERN      9'h1FF
`endif

// ---- rtl/tape_seq_pkg.sv ----
package tape_seq_pkg;
	// gray codes along off, powered, tension, load, ready, rewind, unload, power down
	typedef enum logic [2:0] {
		ST_OFF     = 3'h0,
		ST_POWERED = 3'h1,
		ST_TENSION = 3'h3,
		ST_LOAD    = 3'h2,
		ST_READY   = 3'h6,
		ST_REWIND  = 3'h7,
		ST_UNLOAD  = 3'h5,
		ST_PWRDN   = 3'h4
	} state_type;

	typedef enum logic [1:0] {
		MOT_STOP    = 2'h0,
		MOT_NORMAL  = 2'h1,
		MOT_FAST    = 2'h3,
		MOT_REVERSE = 2'h2
	} motion_type;
endpackage : tape_seq_pkg

// ---- rtl/tape_transport_sequence_interlock.sv ----
`include "tape_seq_defines.svh"

module tape_transport_sequence_interlock
	import tape_seq_pkg::*;
#(
	parameter int unsigned LOAD_TIMEOUT_CYC = `LOAD_TIMEOUT_CYC,
	parameter int unsigned PWROFF_STEP_CYC  = `PWROFF_STEP_CYC
) (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// controller interface
	input  wire logic        unit_select,
	input  wire logic        if_go,
	input  wire logic        if_reverse,
	input  wire logic        if_fast,
	input  wire logic        if_rewind,
	input  wire logic        if_offline,
	input  wire logic        if_set_write,
	output logic             tape_end_flag,
	output logic             at_load_point,
	output logic             file_protect,
	output logic             online,
	output logic             rewinding,
	// front panel and test panel buttons, high while pressed
	input  wire logic        pb_power,
	input  wire logic        pb_load,
	input  wire logic        pb_online,
	input  wire logic        pb_rewind,
	input  wire logic        tp_stop,
	input  wire logic        tp_mode,
	input  wire logic        tp_fwd,
	input  wire logic        tp_rev,
	input  wire logic        tp_fast,
	input  wire logic        tp_cycle,
	input  wire logic        tp_write_test,
	// tape sensors
	input  wire logic        sns_write_ring,
	input  wire logic        sns_load_point,
	input  wire logic        sns_end_of_tape,
	input  wire logic        sns_broken,
	input  wire logic        vacuum_ok,
	input  wire logic        skew_excess,
	// transport commands and relays
	output logic             run_normal_line,
	output logic             run_fast_line,
	output logic             reverse_dir_line,
	output logic             tape_broken,
	output logic             unload,
	output logic             main_power_relay,
	output logic             reel_motor_relay,
	output logic             vacuum_on,
	output logic             sensor_disable,
	output logic             servo_disable,
	// data section and lamps
	output logic             write_permit,
	output logic             write_drivers_on,
	output logic             selected_and_online,
	output logic             write_amp_enable,
	output logic             read_select,
	output logic             read_amp_enable,
	output logic             test_active,
	output logic             write_test_on,
	output logic      [8:0]  test_pattern,
	output logic             lamp_write,
	output logic             lamp_read,
	output logic             lamp_load,
	output logic             lamp_skew,
	output logic             lamp_high_dens,
	output logic             lamp_eot,
	output logic             lamp_load_point
);

	if (LOAD_TIMEOUT_CYC < 2 || PWROFF_STEP_CYC < 1) begin : g_bad_param
		$error("timing parameters too small");
	end

	state_type   state_r;
	motion_type  motion_r;
	motion_type  motion_nxt;
	motion_type  test_mot_r;
	logic [10:0] btn;
	logic [10:0] btn_r;
	logic [10:0] pr;
	logic [31:0] load_cnt_r;
	logic [31:0] step_cnt_r;
	logic [1:0]  pd_step_r;
	logic [31:0] cyc_cnt_r;
	logic [31:0] cycle_len_r;
	logic        ctrl_dens_r;
	logic        lp_r;
	logic        eot_r;
	logic        ring_r;
	logic        online_r;
	logic        broken_r;
	logic        test_arm_r;
	logic        test_r;
	logic        cycling_r;
	logic        wtest_r;
	logic        wperm_r;
	logic        fault;
	logic        sel_on;
	logic        accept;
	logic        loaded;
	logic        load_to;
	logic        apb_wr;
	logic        apb_hit;

	// button press detection; inputs are already synchronous
	assign btn = {tp_write_test, tp_cycle, tp_fast, tp_rev, tp_fwd, tp_mode, tp_stop,
	              pb_rewind, pb_online, pb_load, pb_power};
	assign pr  = btn & ~btn_r;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			btn_r <= '0;
		end else begin
			btn_r <= btn;
		end
	end

	// sensor conditioning, blanked while sensors are disabled
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			lp_r   <= 1'b0;
			eot_r  <= 1'b0;
			ring_r <= 1'b0;
		end else begin
			lp_r   <= sns_load_point & ~sensor_disable;
			eot_r  <= sns_end_of_tape & ~sensor_disable;
			ring_r <= sns_write_ring & ~sensor_disable;
		end
	end

	assign loaded  = (state_r == ST_READY) || (state_r == ST_REWIND);
	assign fault   = sns_broken | ~vacuum_ok;
	assign sel_on  = online_r & unit_select;
	assign accept  = sel_on & (state_r == ST_READY) & ~broken_r;
	assign load_to = (load_cnt_r >= LOAD_TIMEOUT_CYC - 1);

	// main sequencer
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state_r <= ST_OFF;
		end else begin
			unique case (state_r)
				ST_OFF: begin
					if (pr[0]) state_r <= ST_POWERED;
				end
				ST_POWERED: begin
					if (pr[0]) state_r <= ST_PWRDN;
					else if (pr[1]) state_r <= ST_TENSION;
				end
				ST_TENSION: begin
					if (pr[0]) state_r <= ST_PWRDN;
					else if (vacuum_ok) state_r <= ST_LOAD;
				end
				ST_LOAD: begin
					if (fault) state_r <= ST_POWERED;
					else if (pr[0]) state_r <= ST_PWRDN;
					else if (lp_r) state_r <= ST_READY;
					else if (load_to) state_r <= ST_REWIND;
				end
				ST_READY: begin
					if (fault) state_r <= ST_POWERED;
					else if (pr[0]) state_r <= ST_PWRDN;
					else if (accept && if_rewind && !lp_r) state_r <= ST_REWIND;
					else if (pr[3] && !online_r) begin
						state_r <= lp_r ? ST_UNLOAD : ST_REWIND;
					end
				end
				ST_REWIND: begin
					if (fault) state_r <= ST_POWERED;
					else if (pr[0]) state_r <= ST_PWRDN;
					else if (lp_r) state_r <= ST_READY;
				end
				ST_UNLOAD: begin
					// power button has no path out of here
					if (sns_broken) state_r <= ST_POWERED;
				end
				ST_PWRDN: begin
					if (pd_step_r == 2'h3 && step_cnt_r >= PWROFF_STEP_CYC - 1) begin
						state_r <= ST_OFF;
					end
				end
			endcase
		end
	end

	// load timeout, armed by the load press and cleared by load point
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			load_cnt_r <= '0;
		end else if (pr[1] || lp_r || state_r != ST_LOAD) begin
			load_cnt_r <= '0;
		end else if (!load_to) begin
			load_cnt_r <= load_cnt_r + 32'h1;
		end
	end

	// power down step timer
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			step_cnt_r <= '0;
			pd_step_r  <= 2'h0;
		end else if (state_r != ST_PWRDN) begin
			step_cnt_r <= '0;
			pd_step_r  <= 2'h0;
		end else if (step_cnt_r >= PWROFF_STEP_CYC - 1) begin
			step_cnt_r <= '0;
			pd_step_r  <= pd_step_r + 2'h1;
		end else begin
			step_cnt_r <= step_cnt_r + 32'h1;
		end
	end

	// broken flag: set wins over the clear from a new load press
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			broken_r <= 1'b0;
		end else if (fault && state_r inside {ST_LOAD, ST_READY, ST_REWIND, ST_UNLOAD}) begin
			broken_r <= 1'b1;
		end else if (pr[1]) begin
			broken_r <= 1'b0;
		end
	end

	// online: panel toggle, interface offline clears
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			online_r <= 1'b0;
		end else if (!loaded || (accept && if_offline)) begin
			online_r <= 1'b0;
		end else if (pr[2] && state_r == ST_READY) begin
			online_r <= ~online_r;
		end
	end

	// test panel arming; stop then mode, only while offline
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			test_arm_r <= 1'b0;
			test_r     <= 1'b0;
		end else if (online_r || state_r != ST_READY) begin
			test_arm_r <= 1'b0;
			test_r     <= 1'b0;
		end else begin
			if (pr[4]) test_arm_r <= 1'b1;
			if (pr[5] && test_arm_r) test_r <= 1'b1;
		end
	end

	// test motion and cycling; half period comes from software
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			test_mot_r <= MOT_STOP;
			cycling_r  <= 1'b0;
			cyc_cnt_r  <= '0;
			wtest_r    <= 1'b0;
		end else if (!test_r) begin
			test_mot_r <= MOT_STOP;
			cycling_r  <= 1'b0;
			cyc_cnt_r  <= '0;
			wtest_r    <= 1'b0;
		end else if (pr[4]) begin
			test_mot_r <= MOT_STOP;
			cycling_r  <= 1'b0;
			wtest_r    <= 1'b0;
		end else if (pr[9]) begin
			test_mot_r <= MOT_NORMAL;
			cycling_r  <= 1'b1;
			cyc_cnt_r  <= '0;
		end else if (cycling_r) begin
			if (cyc_cnt_r >= cycle_len_r) begin
				cyc_cnt_r  <= '0;
				test_mot_r <= (test_mot_r == MOT_NORMAL) ? MOT_REVERSE : MOT_NORMAL;
			end else begin
				cyc_cnt_r <= cyc_cnt_r + 32'h1;
			end
		end else begin
			if (pr[6]) test_mot_r <= MOT_NORMAL;
			if (pr[7]) test_mot_r <= MOT_REVERSE;
			if (pr[8]) test_mot_r <= MOT_FAST;
			if (pr[10]) begin
				wtest_r    <= ~wtest_r;
				test_mot_r <= MOT_NORMAL;
			end
		end
	end

	// motion decode; fast outranks reverse so only one line rises
	always_comb begin
		motion_nxt = MOT_STOP;
		unique case (state_r)
			ST_LOAD:   motion_nxt = MOT_NORMAL;
			ST_REWIND: motion_nxt = MOT_REVERSE;
			ST_UNLOAD: motion_nxt = MOT_REVERSE;
			ST_READY: begin
				if (accept && if_go) begin
					if (if_fast) motion_nxt = MOT_FAST;
					else if (if_reverse) motion_nxt = MOT_REVERSE;
					else motion_nxt = MOT_NORMAL;
				end else if (test_r) begin
					motion_nxt = test_mot_r;
				end
			end
			default: motion_nxt = MOT_STOP;
		endcase
		if (fault && state_r != ST_UNLOAD) motion_nxt = MOT_STOP;
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			motion_r         <= MOT_STOP;
			run_normal_line  <= 1'b0;
			run_fast_line    <= 1'b0;
			reverse_dir_line <= 1'b0;
		end else begin
			motion_r         <= motion_nxt;
			run_normal_line  <= (motion_nxt == MOT_NORMAL);
			run_fast_line    <= (motion_nxt == MOT_FAST);
			reverse_dir_line <= (motion_nxt == MOT_REVERSE);
		end
	end

	// write permit; end of tape deliberately plays no part
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			wperm_r <= 1'b0;
		end else begin
			wperm_r <= ((accept & if_set_write) | (test_r & wtest_r)) & ring_r
			           & (state_r == ST_READY) & (motion_nxt == MOT_NORMAL);
		end
	end

	// relay and servo sequencing
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			main_power_relay <= 1'b0;
			reel_motor_relay <= 1'b0;
			vacuum_on        <= 1'b0;
			sensor_disable   <= 1'b1;
			servo_disable    <= 1'b1;
			unload           <= 1'b0;
			tape_broken      <= 1'b0;
		end else begin
			main_power_relay <= (state_r != ST_OFF) &&
			                    !(state_r == ST_PWRDN && pd_step_r == 2'h3);
			reel_motor_relay <= !(state_r inside {ST_OFF, ST_POWERED}) && !fault;
			vacuum_on        <= state_r inside {ST_TENSION, ST_LOAD, ST_READY,
			                                    ST_REWIND, ST_UNLOAD};
			sensor_disable   <= state_r inside {ST_OFF, ST_POWERED} ||
			                    (state_r == ST_PWRDN && pd_step_r >= 2'h1);
			servo_disable    <= state_r inside {ST_OFF, ST_POWERED} || fault ||
			                    (state_r == ST_PWRDN && pd_step_r >= 2'h2);
			unload           <= (state_r == ST_UNLOAD);
			tape_broken      <= broken_r | (fault & loaded);
		end
	end

	// status back to the controller; all but online pass only through open gates
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			tape_end_flag       <= 1'b0;
			at_load_point       <= 1'b0;
			file_protect        <= 1'b0;
			online              <= 1'b0;
			rewinding           <= 1'b0;
			selected_and_online <= 1'b0;
		end else begin
			tape_end_flag       <= sel_on & eot_r;
			at_load_point       <= sel_on & lp_r;
			file_protect        <= sel_on & ~ring_r;
			online              <= online_r;
			rewinding           <= sel_on & (state_r == ST_REWIND);
			selected_and_online <= sel_on;
		end
	end

	// data section enables and lamps
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			write_permit     <= 1'b0;
			write_drivers_on <= 1'b0;
			write_amp_enable <= 1'b0;
			read_select      <= 1'b0;
			read_amp_enable  <= 1'b0;
			lamp_write       <= 1'b0;
			lamp_read        <= 1'b0;
		end else begin
			write_permit     <= wperm_r;
			write_drivers_on <= wperm_r;
			lamp_write       <= wperm_r;
			write_amp_enable <= wperm_r & (sel_on | test_r);
			read_select      <= loaded & (state_r != ST_REWIND) & ~wperm_r;
			lamp_read        <= loaded & (state_r != ST_REWIND) & ~wperm_r;
			read_amp_enable  <= loaded & (state_r != ST_REWIND) & ~wperm_r
			                    & (sel_on | test_r);
		end
	end

	// test panel outputs; pattern is all ones while the write test runs with write permit
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			test_active     <= 1'b0;
			write_test_on   <= 1'b0;
			test_pattern    <= 9'h000;
			lamp_skew       <= 1'b0;
			lamp_high_dens  <= 1'b0;
			lamp_eot        <= 1'b0;
			lamp_load_point <= 1'b0;
			lamp_load       <= 1'b0;
		end else begin
			test_active     <= test_r;
			write_test_on   <= test_r & wtest_r;
			test_pattern    <= (test_r & wtest_r & wperm_r) ? `TEST_PATTERN : 9'h000;
			lamp_skew       <= test_r & skew_excess;
			lamp_high_dens  <= test_r & ctrl_dens_r;
			lamp_eot        <= test_r & eot_r;
			lamp_load_point <= test_r & lp_r;
			lamp_load       <= !(state_r inside {ST_OFF, ST_POWERED, ST_PWRDN});
		end
	end

	// apb: zero wait states, read data caught in the setup cycle
	assign apb_hit = (paddr == `REG_CTRL) || (paddr == `REG_CYCLE) || (paddr == `REG_STATUS);
	assign apb_wr  = psel & penable & pwrite & apb_hit;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~apb_hit;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ctrl_dens_r <= `CTRL_RST;
			cycle_len_r <= `CYCLE_RST;
		end else if (apb_wr) begin
			if (paddr == `REG_CTRL) ctrl_dens_r <= pwdata[`CTRL_HIGH_DENS];
			if (paddr == `REG_CYCLE) cycle_len_r <= pwdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			unique case (paddr)
				`REG_CTRL:   prdata <= {31'h0, ctrl_dens_r};
				`REG_CYCLE:  prdata <= cycle_len_r;
				`REG_STATUS: prdata <= {21'h0, eot_r, lp_r, test_r, wperm_r, broken_r,
				                        online_r, motion_r, state_r};
				default:     prdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule : tape_transport_sequence_interlock
